// *** counter_routing_pkg.sv ***
`default_nettype none
package counter_routing_pkg;
  localparam int unsigned ADDR_W     = 9;
  localparam int unsigned NSEL       = 7;
  localparam int unsigned CODE_W     = 6;
  localparam int unsigned ROUTE_W    = 4;
  localparam int unsigned CFG_W      = 10;
  localparam logic [8:0] CTR_STRIDE    = 9'h040;
  localparam logic [3:0] REG_CFG       = 4'h0;
  localparam logic [3:0] REG_SEL0      = 4'h1;
  localparam logic [3:0] REG_SEL6      = 4'h7;
  localparam logic [3:0] REG_LOW       = 4'h8;
  localparam logic [3:0] REG_HIGH      = 4'h9;
  localparam logic [3:0] REG_NPULSE    = 4'hA;
  localparam logic [3:0] REG_CMD       = 4'hB;
  localparam logic [3:0] REG_COUNT     = 4'hC;
  localparam logic [3:0] REG_STATUS    = 4'hD;
  localparam logic [8:0] ROUTE_BASE    = 9'h100;
  localparam logic [5:0] PFI_IDX       = 6'h00;
  localparam logic [5:0] STL_IDX       = 6'h10;
  localparam logic [5:0] SQ_IDX        = 6'h18;
  localparam int unsigned CFG_MODE_LSB  = 0;
  localparam int unsigned CFG_TRIG_LSB  = 2;
  localparam int unsigned CFG_RETRIG    = 4;
  localparam int unsigned CFG_TOGGLE    = 5;
  localparam int unsigned CFG_INVERT    = 6;
  localparam int unsigned CFG_BDIR      = 7;
  localparam int unsigned CFG_HWARM     = 8;
  localparam int unsigned CFG_PAUSE_INV = 9;
  localparam int unsigned CMD_ARM       = 0;
  localparam int unsigned CMD_DISARM    = 1;
  localparam logic [1:0] MODE_EDGE   = 2'h0;
  localparam logic [1:0] MODE_CONT   = 2'h1;
  localparam logic [1:0] MODE_FINITE = 2'h2;
  localparam logic [1:0] TRIG_NONE   = 2'h0;
  localparam logic [1:0] TRIG_START  = 2'h1;
  localparam logic [1:0] TRIG_PAUSE  = 2'h2;
  localparam int unsigned SL_SRC = 0, SL_GATE = 1, SL_AUX = 2, SL_A = 3;
  localparam int unsigned SL_B = 4, SL_Z = 5, SL_ARM = 6;
  localparam int unsigned C_STL = 1, C_PFI = 9, C_STAR = 25, C_ACMP = 26;
  localparam int unsigned C_TB80 = 27, C_TB20 = 28, C_TB100K = 29;
  localparam int unsigned C_CLK10 = 30, C_AIREF = 31, C_AISTART = 32;
  localparam int unsigned C_AISAMP = 33, C_AICONV = 34, C_AOSAMP = 35;
  localparam int unsigned C_DISAMP = 36, C_DOSAMP = 37, C_CHG = 38;
  localparam int unsigned C_OTC = 39, C_OGATE = 40, C_OOUT = 41;
  localparam int unsigned C_OSRC = 42, C_OWNGATE = 43;
  localparam logic [3:0] R_OFF = 4'h0, R_SRC = 4'h1, R_GATE = 4'h2;
  localparam logic [3:0] R_OUT = 4'h3, R_Z = 4'h4, R_SQ = 4'h9;
  localparam logic [3:0] R_C1  = 4'h4;
  typedef enum logic [2:0] {
    CS_IDLE = 3'b001,
    CS_WAIT = 3'b010,
    CS_RUN  = 3'b100
  } cstate_t;
endpackage
`default_nettype wire

// *** counter_routing.sv ***
`default_nettype none
// Functional notes
// - Source selector offers timebases, lines, reference, star, comparator.
// - Source selector offers other counter terminal count, gate.
// - Selected source drivable onto any function/trigger line.
// - Function lines undriven until routing is configured.
// - Gate selector offers lines, acquisition clocks and events.
// - Gate selector offers other counter output and source.
// - Selected gate drivable onto any function/trigger line.
// - Aux selector marks first edge of separation.
// - Aux also offers other output, gate, source, own gate.
// - B input sets edge counting direction.
// - Separate A, B, Z selectors from lines, star, comparator.
// - Z input drivable onto system trigger lines only.
// - Counter does nothing until armed.
// - Arm by software command or selected hardware input.
// - Hardware arm also offers other counter internal output.
// - Output pulses or toggles on terminal count, invertible.
// - Internal output carries the output pulses or toggles, routable internally.
// - Internal output drivable onto any function/trigger line.
// - Square wave routable to function lines and clocks.
// - Continuous runs until stopped; finite stops; retrigger restarts.
// - Start trigger via gate, arm via hardware arm.
// - Pause via gate stops counting at inactive level.
module counter_routing
  import counter_routing_pkg::*;
(
  input  wire logic                                  clock,
  input  wire logic                                  nrst,
  input  wire logic [counter_routing_pkg::ADDR_W-1:0] address,
  input  wire logic                                  read,
  input  wire logic                                  write,
  input  wire logic [31:0]                           writedata,
  output logic      [31:0]                           readdata,
  output logic                                       waitrequest,
  input  wire logic                                  timebase_80mhz,
  input  wire logic                                  timebase_20mhz,
  input  wire logic                                  timebase_100khz,
  input  wire logic                                  backplane_10mhz_reference,
  input  wire logic                                  backplane_star_trigger,
  input  wire logic                                  analog_comparison_event,
  input  wire logic                                  analog_in_reference_trigger,
  input  wire logic                                  analog_in_start_trigger,
  input  wire logic                                  analog_in_sample_clock,
  input  wire logic                                  analog_in_convert_clock,
  input  wire logic                                  analog_out_sample_clock,
  input  wire logic                                  digital_in_sample_clock,
  input  wire logic                                  digital_out_sample_clock,
  input  wire logic                                  change_detection_event,
  input  wire logic                                  square_wave_out,
  input  wire logic [15:0]                           programmable_function_line_in,
  output logic      [15:0]                           programmable_function_line_out,
  output logic      [15:0]                           programmable_function_line_oe,
  input  wire logic [7:0]                            system_trigger_line_in,
  output logic      [7:0]                            system_trigger_line_out,
  output logic      [7:0]                            system_trigger_line_oe,
  output logic      [1:0]                            counter_internal_output,
  output logic      [1:0]                            counter_aux_edge,
  output logic                                       square_wave_do_clock,
  output logic                                       square_wave_di_clock
);
  import counter_routing_pkg::*;

  typedef struct packed {
    logic                               wait_n;
    logic [31:0]                        rdata;
    logic [1:0][CFG_W-1:0]              cfg;
    logic [1:0][NSEL-1:0][CODE_W-1:0]   sel;
    logic [1:0][31:0]                   low_ld;
    logic [1:0][31:0]                   high_ld;
    logic [1:0][31:0]                   npulse;
    logic [1:0][31:0]                   count;
    logic [1:0][31:0]                   done;
    cstate_t [1:0]                      cst;
    logic [1:0][NSEL-1:0]               sig;
    logic [1:0]                         src_prev;
    logic [1:0]                         arm_prev;
    logic [1:0]                         gs1;
    logic [1:0]                         gs2;
    logic [1:0]                         gs3;
    logic [1:0]                         phase;
    logic [1:0]                         tog;
    logic [1:0]                         tc;
    logic [1:0]                         out;
    logic [15:0][ROUTE_W-1:0]           pfi_route;
    logic [7:0][ROUTE_W-1:0]            stl_route;
    logic [1:0]                         sq_route;
    logic [15:0]                        pfi_o;
    logic [15:0]                        pfi_oe;
    logic [7:0]                         stl_o;
    logic [7:0]                         stl_oe;
    logic [1:0]                         sq_clk;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic sel_ok(input int unsigned slot,
                                  input logic [CODE_W-1:0] code);
    logic line;
    line = (code >= 6'(C_STL)) && (code <= 6'(C_ACMP));
    unique case (slot)
      SL_SRC:  sel_ok = line || (code >= 6'(C_TB80) && code <= 6'(C_CLK10))
                        || code == 6'(C_OTC) || code == 6'(C_OGATE);
      SL_GATE: sel_ok = line || (code >= 6'(C_AIREF) && code <= 6'(C_CHG))
                        || code == 6'(C_OOUT) || code == 6'(C_OSRC);
      SL_AUX:  sel_ok = line || code == 6'(C_AIREF) || code == 6'(C_AISTART)
                        || (code >= 6'(C_OGATE) && code <= 6'(C_OWNGATE));
      SL_ARM:  sel_ok = line || code == 6'(C_AIREF) || code == 6'(C_AISTART)
                        || code == 6'(C_OOUT);
      default: sel_ok = line;
    endcase
  endfunction

  function automatic logic [1:0] route_drive(input logic [ROUTE_W-1:0] code,
                                             input logic programmable_function_line,
                                             input state_t s,
                                             input logic sq);
    logic [1:0] r;
    int unsigned k;
    r = 2'b00;
    k = (code >= R_C1 + 4'h1 && code <= R_C1 + R_Z) ? 1 : 0;
    unique case (code)
      R_SRC, R_C1 + R_SRC:   r = {1'b1, s.sig[k][SL_SRC]};
      R_GATE, R_C1 + R_GATE: r = {1'b1, s.sig[k][SL_GATE]};
      R_OUT, R_C1 + R_OUT:   r = {1'b1, s.out[k]};
      R_Z, R_C1 + R_Z:       r = programmable_function_line ? 2'b00 : {1'b1, s.sig[k][SL_Z]};
      R_SQ:                  r = programmable_function_line ? {1'b1, sq} : 2'b00;
      default:               r = 2'b00;
    endcase
    route_drive = r;
  endfunction

  always_comb begin
    logic [63:0] cand;
    logic        req, wr, ctr_hit, se, gedge, paused, do_arm, do_disarm, up;
    logic [1:0]  mode, trig, drv;
    logic [31:0] ld;
    logic [5:0]  ridx;
    logic [3:0]  ro;
    int unsigned o, ci;
    cand = '0;
    req = 1'b0;
    wr = 1'b0;
    ctr_hit = 1'b0;
    mode = '0;
    trig = '0;
    se = 1'b0;
    gedge = 1'b0;
    paused = 1'b0;
    do_arm = 1'b0;
    do_disarm = 1'b0;
    up = 1'b0;
    ld = '0;
    drv = '0;
    ridx = '0;
    ro = '0;
    o = 0;
    ci = 0;
    st_nxt = st_r;

    // Bus slave: one wait cycle, then a single answer cycle.
    req = read || write;
    wr = write && !st_r.wait_n;
    st_nxt.wait_n = !(req && st_r.wait_n);
    ci = address[6] ? 1 : 0;
    ctr_hit = !address[8] && !address[7];
    ridx = address[7:2];
    ro = address[5:2];
    if (req && st_r.wait_n) begin
      st_nxt.rdata = 32'h0000_0000;
      if (ctr_hit) begin
        case (ro)
          REG_CFG:    st_nxt.rdata = 32'(st_r.cfg[ci]);
          REG_LOW:    st_nxt.rdata = st_r.low_ld[ci];
          REG_HIGH:   st_nxt.rdata = st_r.high_ld[ci];
          REG_NPULSE: st_nxt.rdata = st_r.npulse[ci];
          REG_COUNT:  st_nxt.rdata = st_r.count[ci];
          REG_STATUS: st_nxt.rdata = {26'h000_0000, st_r.out[ci],
                                      st_r.phase[ci], st_r.sig[ci][SL_GATE],
                                      st_r.cst[ci]};
          default:
            if (ro <= REG_SEL6)
              st_nxt.rdata = 32'(st_r.sel[ci][ro - REG_SEL0]);
        endcase
      end else if (address[8]) begin
        if (ridx < STL_IDX)
          st_nxt.rdata = 32'(st_r.pfi_route[ridx[3:0]]);
        else if (ridx < SQ_IDX)
          st_nxt.rdata = 32'(st_r.stl_route[ridx[2:0]]);
        else if (ridx == SQ_IDX)
          st_nxt.rdata = 32'(st_r.sq_route);
      end
    end
    if (wr && ctr_hit) begin
      case (ro)
        REG_CFG:    st_nxt.cfg[ci] = writedata[CFG_W-1:0];
        REG_LOW:    st_nxt.low_ld[ci] = writedata;
        REG_HIGH:   st_nxt.high_ld[ci] = writedata;
        REG_NPULSE: st_nxt.npulse[ci] = writedata;
        default:
          if (ro <= REG_SEL6)
            st_nxt.sel[ci][ro - REG_SEL0] = writedata[CODE_W-1:0];
      endcase
    end else if (wr && address[8]) begin
      if (ridx < STL_IDX)
        st_nxt.pfi_route[ridx[3:0]] = writedata[ROUTE_W-1:0];
      else if (ridx < SQ_IDX)
        st_nxt.stl_route[ridx[2:0]] = writedata[ROUTE_W-1:0];
      else if (ridx == SQ_IDX)
        st_nxt.sq_route = writedata[1:0];
    end

    for (int i = 0; i < 2; i++) begin
      o = 1 - i;
      cand = '0;
      cand[C_STL +: 8] = system_trigger_line_in;
      cand[C_PFI +: 16] = programmable_function_line_in;
      cand[C_STAR] = backplane_star_trigger;
      cand[C_ACMP] = analog_comparison_event;
      cand[C_TB80] = timebase_80mhz;
      cand[C_TB20] = timebase_20mhz;
      cand[C_TB100K] = timebase_100khz;
      cand[C_CLK10] = backplane_10mhz_reference;
      cand[C_AIREF] = analog_in_reference_trigger;
      cand[C_AISTART] = analog_in_start_trigger;
      cand[C_AISAMP] = analog_in_sample_clock;
      cand[C_AICONV] = analog_in_convert_clock;
      cand[C_AOSAMP] = analog_out_sample_clock;
      cand[C_DISAMP] = digital_in_sample_clock;
      cand[C_DOSAMP] = digital_out_sample_clock;
      cand[C_CHG] = change_detection_event;
      cand[C_OTC] = st_r.tc[o];
      cand[C_OGATE] = st_r.sig[o][SL_GATE];
      cand[C_OOUT] = st_r.out[o];
      cand[C_OSRC] = st_r.sig[o][SL_SRC];
      cand[C_OWNGATE] = st_r.sig[i][SL_GATE];
      for (int k = 0; k < NSEL; k++)
        st_nxt.sig[i][k] = sel_ok(k, st_r.sel[i][k]) &&
                           cand[st_r.sel[i][k]];

      mode = st_r.cfg[i][CFG_MODE_LSB +: 2];
      trig = st_r.cfg[i][CFG_TRIG_LSB +: 2];
      se = st_r.sig[i][SL_SRC] && !st_r.src_prev[i];
      st_nxt.src_prev[i] = st_r.sig[i][SL_SRC];
      if (se) begin
        st_nxt.gs1[i] = st_r.sig[i][SL_GATE];
        st_nxt.gs2[i] = st_r.gs1[i];
        st_nxt.gs3[i] = st_r.gs2[i];
      end
      gedge = se && st_r.gs2[i] && !st_r.gs3[i];
      paused = (trig == TRIG_PAUSE) &&
               !(st_r.gs2[i] ^ st_r.cfg[i][CFG_PAUSE_INV]);
      st_nxt.arm_prev[i] = st_r.sig[i][SL_ARM];
      do_arm = (wr && ctr_hit && ci == i && address[5:2] == REG_CMD &&
                writedata[CMD_ARM]) ||
               (st_r.cfg[i][CFG_HWARM] && st_r.sig[i][SL_ARM] &&
                !st_r.arm_prev[i]);
      do_disarm = wr && ctr_hit && ci == i && address[5:2] == REG_CMD &&
                  writedata[CMD_DISARM];
      up = st_r.cfg[i][CFG_BDIR] ? st_r.sig[i][SL_B] : 1'b1;
      st_nxt.tc[i] = 1'b0;
      ld = st_r.low_ld[i];

      unique case (st_r.cst[i])
        CS_IDLE, CS_WAIT: begin
          if (st_r.cst[i] == CS_IDLE ? do_arm : gedge) begin
            st_nxt.cst[i] = (st_r.cst[i] == CS_IDLE && trig == TRIG_START)
                            ? CS_WAIT : CS_RUN;
            st_nxt.count[i] = (mode == MODE_EDGE) ? st_r.count[i] : ld;
            st_nxt.done[i] = '0;
            st_nxt.phase[i] = 1'b0;
          end
        end
        CS_RUN: begin
          if (se && !paused) begin
            if (mode == MODE_EDGE) begin
              st_nxt.count[i] = up ? st_r.count[i] + 32'h0000_0001
                                   : st_r.count[i] - 32'h0000_0001;
              st_nxt.tc[i] = up ? (&st_r.count[i]) : (st_r.count[i] == '0);
            end else if (st_r.count[i] <= 32'h0000_0001) begin
              st_nxt.tc[i] = 1'b1;
              st_nxt.phase[i] = !st_r.phase[i];
              st_nxt.count[i] = st_r.phase[i] ? st_r.low_ld[i]
                                              : st_r.high_ld[i];
              if (st_r.phase[i]) begin
                st_nxt.done[i] = st_r.done[i] + 32'h0000_0001;
                if (mode == MODE_FINITE &&
                    st_r.done[i] + 32'h0000_0001 >= st_r.npulse[i])
                  st_nxt.cst[i] = (st_r.cfg[i][CFG_RETRIG] &&
                                   trig == TRIG_START) ? CS_WAIT
                                                       : CS_IDLE;
              end
            end else begin
              st_nxt.count[i] = st_r.count[i] - 32'h0000_0001;
            end
          end
        end
      endcase
      if (do_disarm)
        st_nxt.cst[i] = CS_IDLE;
      st_nxt.tog[i] = st_r.tog[i] ^ st_nxt.tc[i];
      st_nxt.out[i] = st_r.cfg[i][CFG_INVERT] ^
                      (st_r.cfg[i][CFG_TOGGLE] ? st_nxt.tog[i]
                                               : st_nxt.tc[i]);
    end

    for (int j = 0; j < 16; j++) begin
      drv = route_drive(st_r.pfi_route[j], 1'b1, st_r, square_wave_out);
      st_nxt.pfi_oe[j] = drv[1];
      st_nxt.pfi_o[j] = drv[0];
    end
    for (int j = 0; j < 8; j++) begin
      drv = route_drive(st_r.stl_route[j], 1'b0, st_r, square_wave_out);
      st_nxt.stl_oe[j] = drv[1];
      st_nxt.stl_o[j] = drv[0];
    end
    st_nxt.sq_clk = st_r.sq_route & {2{square_wave_out}};
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.wait_n <= 1'b1;
      st_r.cst <= {CS_IDLE, CS_IDLE};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign readdata = st_r.rdata;
  assign waitrequest = st_r.wait_n;
  assign programmable_function_line_out = st_r.pfi_o;
  assign programmable_function_line_oe = st_r.pfi_oe;
  assign system_trigger_line_out = st_r.stl_o;
  assign system_trigger_line_oe = st_r.stl_oe;
  assign counter_internal_output = st_r.out;
  assign counter_aux_edge = {st_r.sig[1][SL_AUX], st_r.sig[0][SL_AUX]};
  assign square_wave_do_clock = st_r.sq_clk[0];
  assign square_wave_di_clock = st_r.sq_clk[1];
endmodule
`default_nettype wire

// *** far_side_model.sv ***
`default_nettype none
module far_side_model (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [15:0] ctl,
  input  wire logic [15:0] fl_out,
  input  wire logic [15:0] fl_oe,
  input  wire logic [7:0]  stl_out,
  input  wire logic [7:0]  stl_oe,
  output logic      [15:0] fl_in,
  output logic      [7:0]  stl_in,
  output logic             src,
  output logic             sq,
  output logic      [13:0] tim
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] div_r;
  always_ff @(posedge clock) begin
    div_r <= nrst ? div_r + 8'h01 : 8'h00;
  end
  assign src = div_r[2];
  assign sq  = div_r[3];
  assign tim = {div_r[6:0], div_r[7:1]};
  always_comb begin
    for (int j = 0; j < 16; j++) begin
      fl_in[j] = fl_oe[j] ? fl_out[j] : ((j == 5) ? src : ctl[j]);
    end
    for (int k = 0; k < 8; k++) begin
      stl_in[k] = stl_oe[k] ? stl_out[k] : div_r[k % 3];
    end
  end
endmodule
`default_nettype wire

// *** counter_routing_asserts.sv ***
`default_nettype none
module counter_routing_asserts
  import counter_routing_pkg::*;
(
  input wire logic                                   clock,
  input wire logic                                   nrst,
  input wire logic [counter_routing_pkg::ADDR_W-1:0] address,
  input wire logic                                   read,
  input wire logic                                   write,
  input wire logic [31:0]                            writedata,
  input wire logic [31:0]                            readdata,
  input wire logic                                   waitrequest,
  input wire logic [15:0]                  programmable_function_line_oe,
  input wire logic [7:0]                             system_trigger_line_oe,
  input wire logic                                   square_wave_do_clock
);
  logic [3:0] fl0_r;
  logic [3:0] stl0_r;
  logic       sqdo_r;
  logic       fl_drv;
  logic       stl_drv;
  assign fl_drv  = fl0_r inside {[4'h1:4'h3], [4'h5:4'h7], 4'h9};
  assign stl_drv = stl0_r inside {[4'h1:4'h8]};
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fl0_r  <= R_OFF;
      stl0_r <= R_OFF;
      sqdo_r <= 1'b0;
    end else if (write && !waitrequest) begin
      if (address[8:2] == 7'h40) fl0_r <= writedata[3:0];
      if (address[8:2] == 7'h50) stl0_r <= writedata[3:0];
      if (address[8:2] == 7'h58) sqdo_r <= writedata[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  property p_answer;
    s_req |=> s_answer;
  endproperty
  property p_quiet;
    !(read || write) && waitrequest |=> waitrequest;
  endproperty
  property p_reset;
    $rose(nrst) |-> waitrequest && readdata == 32'h0000_0000 &&
      programmable_function_line_oe == 16'h0000 &&
      system_trigger_line_oe == 8'h00;
  endproperty
  property p_fl_on;
    fl_drv [*3] |-> programmable_function_line_oe[0];
  endproperty
  property p_fl_off;
    !fl_drv [*3] |-> !programmable_function_line_oe[0];
  endproperty
  property p_stl_on;
    stl_drv [*3] |-> system_trigger_line_oe[0];
  endproperty
  property p_stl_off;
    !stl_drv [*3] |-> !system_trigger_line_oe[0];
  endproperty
  property p_sq_off;
    !sqdo_r [*3] |-> !square_wave_do_clock;
  endproperty
  a_answer: assert property (p_answer) else $error("no one-cycle answer");
  a_quiet: assert property (p_quiet) else $error("answer without request");
  a_reset: assert property (p_reset) else $error("bad reset state");
  a_fl_on: assert property (p_fl_on) else $error("line not driven");
  a_fl_off: assert property (p_fl_off) else $error("line driven");
  a_stl_on: assert property (p_stl_on) else $error("trig undriven");
  a_stl_off: assert property (p_stl_off) else $error("trig driven");
  a_sq_off: assert property (p_sq_off) else $error("clock leaks");
endmodule
bind counter_routing counter_routing_asserts counter_routing_asserts_i (
  .clock(clock), .nrst(nrst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest),
  .programmable_function_line_oe(programmable_function_line_oe),
  .system_trigger_line_oe(system_trigger_line_oe),
  .square_wave_do_clock(square_wave_do_clock));
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import counter_routing_pkg::*;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        rdq = 1'b0;
  logic        wrq = 1'b0;
  logic [8:0]  adr = '0;
  logic [31:0] wd = '0;
  logic [31:0] rdat, rd;
  logic        wreq, src, sq, sdo, sdi;
  logic [15:0] ctl = '0;
  logic [15:0] pin, pout, poe;
  logic [7:0]  tin, tout, toe;
  logic [13:0] tim;
  logic [1:0]  co;
  int          fails = 0;
  int          total_checks = 0;
  always #2 clock = ~clock;
  far_side_model far_side_model_i (.clock(clock), .nrst(nrst), .ctl(ctl),
    .fl_out(pout), .fl_oe(poe), .stl_out(tout), .stl_oe(toe),
    .fl_in(pin), .stl_in(tin), .src(src), .sq(sq), .tim(tim));
  counter_routing counter_routing_i (.clock(clock), .nrst(nrst),
    .address(adr), .read(rdq), .write(wrq), .writedata(wd),
    .readdata(rdat), .waitrequest(wreq),
    .timebase_80mhz(tim[0]), .timebase_20mhz(tim[1]),
    .timebase_100khz(tim[2]), .backplane_10mhz_reference(tim[3]),
    .backplane_star_trigger(tim[4]), .analog_comparison_event(tim[5]),
    .analog_in_reference_trigger(tim[6]), .analog_in_start_trigger(tim[7]),
    .analog_in_sample_clock(tim[8]), .analog_in_convert_clock(tim[9]),
    .analog_out_sample_clock(tim[10]), .digital_in_sample_clock(tim[11]),
    .digital_out_sample_clock(tim[12]), .change_detection_event(tim[13]),
    .square_wave_out(sq), .programmable_function_line_in(pin),
    .programmable_function_line_out(pout),
    .programmable_function_line_oe(poe), .system_trigger_line_in(tin),
    .system_trigger_line_out(tout), .system_trigger_line_oe(toe),
    .counter_internal_output(co), .counter_aux_edge(),
    .square_wave_do_clock(sdo), .square_wave_di_clock(sdi));
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [8:0] ca(input int c, input logic [3:0] r);
    return 9'(c) * CTR_STRIDE + {3'b000, r, 2'b00};
  endfunction
  function automatic logic [8:0] ra(input logic [5:0] i);
    return ROUTE_BASE + {1'b0, i, 2'b00};
  endfunction
  task automatic bus(input logic w, input logic [8:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    adr <= a;
    wd <= d;
    wrq <= w;
    rdq <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    if (n >= 64) fails++;
    rd = rdat;
    rdq <= 1'b0;
    wrq <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic st(input int c, input cstate_t s);
    bus(1'b0, ca(c, REG_STATUS), '0);
    chk("state", 32'(s), 32'(rd[2:0]));
  endtask
  task automatic tog(input int n, output int k);
    logic p;
    k = 0;
    p = co[0];
    repeat (n) begin
      @(posedge clock);
      if (co[0] !== p) k++;
      p = co[0];
    end
  endtask
  task automatic t_reset();
    chk("fl_oe", '0, {16'h0, poe});
    chk("stl_oe", '0, {24'h0, toe});
    for (int s = 0; s < 14; s++) begin
      bus(1'b0, ca(s / 7, REG_SEL0 + 4'(s % 7)), '0);
      chk("selector", '0, rd);
    end
    bus(1'b1, 9'h03C, 32'h1234_5678);
    bus(1'b0, 9'h03C, '0);
    chk("unmapped", '0, rd);
    $display("t_reset done");
  endtask
  task automatic t_route();
    bus(1'b1, ca(0, REG_SEL0), 32'(C_PFI + 5));
    bus(1'b1, ca(0, REG_SEL0 + 4'h1), 32'(C_PFI + 6));
    bus(1'b1, ca(1, REG_SEL0 + 4'h1), 32'(C_OSRC));
    bus(1'b1, ra(PFI_IDX), 32'(R_SRC));
    bus(1'b1, ra(PFI_IDX + 6'h2), 32'(R_C1 + R_GATE));
    bus(1'b1, ra(STL_IDX), 32'(R_GATE));
    bus(1'b1, ra(PFI_IDX + 6'h1), 32'(R_SQ));
    bus(1'b1, ra(SQ_IDX), 32'h0000_0001);
    ctl <= 16'h0040;
    @(posedge src);
    tick(4);
    chk("src_hi", 32'h3, {30'h0, pout[2], pout[0]});
    chk("gate_out", 32'h3, {30'h0, toe[0], tout[0]});
    @(negedge src);
    tick(4);
    chk("src_lo", '0, {30'h0, pout[2], pout[0]});
    @(posedge sq);
    tick(4);
    chk("sq_routes", 32'h6, {29'h0, pout[1], sdo, sdi});
    bus(1'b1, ra(PFI_IDX), 32'(R_Z));
    bus(1'b1, ra(STL_IDX), 32'(R_SQ));
    bus(1'b1, ra(STL_IDX + 6'h1), 32'(R_Z));
    tick(4);
    chk("z_fl_oe", '0, {31'h0, poe[0]});
    chk("z_stl_oe", 32'h2, {30'h0, toe[1:0]});
    $display("t_route done");
  endtask
  task automatic t_cont();
    int   k;
    logic p;
    bus(1'b1, ca(0, REG_LOW), 32'h0000_0002);
    bus(1'b1, ca(0, REG_HIGH), 32'h0000_0002);
    bus(1'b1, ca(0, REG_CFG), 32'h0000_0021);
    bus(1'b1, ra(STL_IDX + 6'h1), 32'(R_OUT));
    tog(64, k);
    chk("idle_toggles", '0, 32'(k));
    st(0, CS_IDLE);
    bus(1'b1, ca(0, REG_CMD), 32'h0000_0001);
    st(0, CS_RUN);
    tog(128, k);
    chk("run_toggles", 32'h1, 32'(k inside {[7:9]}));
    chk("out_oe", 32'h1, {31'h0, toe[1]});
    st(0, CS_RUN);
    bus(1'b1, ca(0, REG_CMD), 32'h0000_0003);
    tick(8);
    tog(64, k);
    chk("stopped", '0, 32'(k));
    p = co[0];
    bus(1'b1, ca(0, REG_CFG), 32'h0000_0061);
    tick(4);
    chk("invert", {31'h0, !p}, {31'h0, co[0]});
    $display("t_cont done");
  endtask
  task automatic gp(output int k);
    int k2;
    ctl <= '0;
    tick(32);
    ctl <= 16'h0040;
    tog(40, k);
    ctl <= '0;
    tog(80, k2);
    k = k + k2;
  endtask
  task automatic t_finite();
    int k;
    bus(1'b1, ca(0, REG_LOW), 32'h0000_0001);
    bus(1'b1, ca(0, REG_HIGH), 32'h0000_0001);
    bus(1'b1, ca(0, REG_NPULSE), 32'h0000_0002);
    bus(1'b1, ca(0, REG_CFG), 32'h0000_0006);
    bus(1'b1, ca(0, REG_CMD), 32'h0000_0001);
    st(0, CS_WAIT);
    gp(k);
    st(0, CS_IDLE);
    bus(1'b1, ca(0, REG_CFG), 32'h0000_0016);
    bus(1'b1, ca(0, REG_CMD), 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      gp(k);
      chk("pulses", 32'h1, 32'(k > 0));
      st(0, CS_WAIT);
    end
    $display("t_finite done");
  endtask
  task automatic t_pause();
    logic [31:0] a;
    bus(1'b1, ca(1, REG_SEL0), 32'(C_PFI + 5));
    bus(1'b1, ca(1, REG_SEL0 + 4'h1), 32'(C_PFI + 6));
    bus(1'b1, ca(1, REG_SEL6), 32'(C_PFI + 7));
    bus(1'b1, ca(1, REG_CFG), 32'h0000_0108);
    tick(64);
    st(1, CS_IDLE);
    ctl <= 16'h0080;
    tick(40);
    ctl <= '0;
    st(1, CS_RUN);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) ctl <= 16'h0040;
      if (i == 2) bus(1'b1, ca(1, REG_CFG), 32'h0000_0308);
      tick(32);
      bus(1'b0, ca(1, REG_COUNT), '0);
      a = rd;
      tick(64);
      bus(1'b0, ca(1, REG_COUNT), '0);
      chk("count_step", 32'(i == 1), 32'((rd - a) inside {[7:9]}));
      chk("count_hold", 32'(i != 1), 32'(rd === a));
    end
    $display("t_pause done");
  endtask
  initial begin
    tick(10);
    nrst <= 1'b1;
    t_reset();
    t_route();
    t_cont();
    t_finite();
    t_pause();
    close_out();
  end
  initial begin
    tick(20000);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
